// ---- inc/bdc_pkg.sv ----
`default_nettype none
package bdc_pkg;

    // ****************************************************************
    // Special-purpose register numbers
    // ****************************************************************
    localparam int unsigned SPR_AW    = 10;
    localparam logic [9:0]  SPR_CAUSE = 10'h094;
    localparam logic [9:0]  SPR_MASK  = 10'h095;
    localparam logic [9:0]  SPR_CNT_A = 10'h096;
    localparam logic [9:0]  SPR_CNT_B = 10'h097;
    localparam logic [9:0]  SPR_LCTL  = 10'h09d;

    // ****************************************************************
    // Counter register layout (bit 0 of the word is its LSB)
    // ****************************************************************
    localparam int unsigned CNT_VAL_LSB = 16;
    localparam int unsigned CNT_VAL_W   = 16;
    localparam int unsigned CNT_SRC_LSB = 0;
    localparam int unsigned CNT_RSV_W   = 14;
    localparam logic [15:0] CNT_ONE     = 16'h0001;
    localparam logic [15:0] CNT_ZERO    = 16'h0000;

    typedef enum logic [1:0] {
        SRC_OFF  = 2'h0,
        SRC_IBUS = 2'h1,
        SRC_LBUS = 2'h2,
        SRC_RSVD = 2'h3
    } bdc_src_type;

    // ****************************************************************
    // Load/store-bus watch control layout
    // ****************************************************************
    localparam int unsigned LW_SLICE_W  = 10;
    localparam int unsigned LW0_LSB     = 22;
    localparam int unsigned LW1_LSB     = 12;
    localparam int unsigned LWS_EN      = 9;
    localparam int unsigned LWS_IA      = 7;
    localparam int unsigned LWS_IADC    = 6;
    localparam int unsigned LWS_LA      = 4;
    localparam int unsigned LWS_LADC    = 3;
    localparam int unsigned LWS_LD      = 1;
    localparam int unsigned LWS_LDDC    = 0;
    localparam int unsigned BRK_NOMASK  = 11;
    localparam int unsigned SLW0_BIT    = 3;
    localparam int unsigned SLW1_BIT    = 2;
    localparam logic [31:0] LCTL_RESET  = 32'h0000_0000;
    localparam logic [31:0] LCTL_WMASK  = 32'hffff_f80c;

    typedef enum logic [1:0] {
        PAIR_A   = 2'h0,
        PAIR_B   = 2'h1,
        PAIR_AND = 2'h2,
        PAIR_OR  = 2'h3
    } bdc_pair_type;

    // ****************************************************************
    // Debug entry cause and mask
    // ****************************************************************
    localparam logic [31:0] CAUSE_VALID = 32'h3fe7_400f;
    localparam logic [31:0] CAUSE_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET  = 32'h2002_000f;
    localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;
    localparam int unsigned CAUSE_CHECKSTOP_CAUSE = 29;
    localparam int unsigned CAUSE_LOADBUS_BREAKPOINT_CAUSE  = 3;
    localparam int unsigned CAUSE_INSTRBUS_BREAKPOINT_CAUSE  = 2;

    function automatic logic bdc_pair_sel(input logic [1:0] sel,
                                          input logic       a,
                                          input logic       b);
        case (bdc_pair_type'(sel))
            PAIR_A:   return a;
            PAIR_B:   return b;
            PAIR_AND: return a & b;
            default:  return a | b;
        endcase
    endfunction

endpackage
`default_nettype wire

// ---- rtl/bdc_bp_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module bdc_bp_counter (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        wr_en,
    input  wire logic [31:0] wdata,
    input  wire logic        ibus_evt,
    input  wire logic        lbus_evt,
    output logic      [31:0] reg_value,
    output logic             exp_ibus,
    output logic             exp_lbus
);
    typedef struct packed {
        logic [15:0]          count;
        bdc_pkg::bdc_src_type src;
        logic                 exp_i;
        logic                 exp_l;
    } bdc_cnt_state_type;

    bdc_cnt_state_type r_ff;
    bdc_cnt_state_type nxt_r;
    logic              evt;

    // ****************************************************************
    // Counting
    // ****************************************************************
    assign evt = (r_ff.src == bdc_pkg::SRC_IBUS && ibus_evt)
               | (r_ff.src == bdc_pkg::SRC_LBUS && lbus_evt);

    always_comb begin
        nxt_r       = r_ff;
        nxt_r.exp_i = 1'b0;
        nxt_r.exp_l = 1'b0;
        if (wr_en) begin
            // A write reloads the preset and drops any pending event
            nxt_r.count = wdata[bdc_pkg::CNT_VAL_LSB +: bdc_pkg::CNT_VAL_W];
            nxt_r.src   = bdc_pkg::bdc_src_type'(
                              wdata[bdc_pkg::CNT_SRC_LSB +: 2]);
        end else if (evt && r_ff.count != bdc_pkg::CNT_ZERO) begin
            nxt_r.count = r_ff.count - bdc_pkg::CNT_ONE;
            if (r_ff.count == bdc_pkg::CNT_ONE) begin
                nxt_r.exp_i = (r_ff.src == bdc_pkg::SRC_IBUS);
                nxt_r.exp_l = (r_ff.src == bdc_pkg::SRC_LBUS);
            end
        end
    end

    // Preset has no defined reset value; zero is as good as any
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign reg_value = {r_ff.count, {bdc_pkg::CNT_RSV_W{1'b0}}, r_ff.src};
    assign exp_ibus  = r_ff.exp_i;
    assign exp_lbus  = r_ff.exp_l;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_cnt_expire: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !wr_en && evt && r_ff.count == bdc_pkg::CNT_ONE
        |=> (exp_ibus || exp_lbus) && r_ff.count == bdc_pkg::CNT_ZERO)
        else $error("counter did not expire at one");
    a_cnt_idle_src: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (r_ff.src == bdc_pkg::SRC_OFF || r_ff.src == bdc_pkg::SRC_RSVD)
        && !wr_en |=> $stable(r_ff.count) && !exp_ibus && !exp_lbus)
        else $error("inactive counter moved");
    a_cnt_reset_src: assert property (@(posedge sys_clk) disable iff (1'b0)
        !rst_n |-> reg_value[bdc_pkg::CNT_VAL_LSB-1:0] == 16'h0000)
        else $error("control half not clear in reset");
    c_cnt_expire: cover property (@(posedge sys_clk) disable iff (!rst_n)
        exp_ibus || exp_lbus);

endmodule // bdc_bp_counter
`default_nettype wire

// ---- rtl/bdc_debug_core.sv ----
// Overview of operation
// - Watch control register resets to all zeros; every watchpoint starts off.
// - Watchpoint fires only when enabled and each address, load address and data term it cares about matches.
// - Counter A: 16-bit preset, lower control half cleared by reset.
// - Counter A source: off, first instruction watch, first load watch.
// - Counter B: 16-bit preset, lower control half cleared by reset.
// - Counter B source: off, second instruction watch, second load watch.
// - Cause register records debug entry events; only hardware sets bits.
// - Reading cause clears it when debug disabled or in debug mode.
// - Software writes to the cause register change nothing.
// - Debug entry needs debug enabled and the matching mask bit.
// - Cause register resets to all zeros.
// - Each exception event sets its own cause bit; instruction breakpoints share bit 2 and load-bus breakpoints share bit 3.
// - Mask register holds one enable bit per cause bit.
`timescale 1ns/1ps
`default_nettype none
module bdc_debug_core (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        spr_wr_en,
    input  wire logic        spr_rd_en,
    input  wire logic [9:0]  spr_addr,
    input  wire logic [31:0] spr_wdata,
    input  wire logic [3:0]  ibus_watch,
    input  wire logic [3:0]  cmp_match,
    input  wire logic [31:0] core_cause_evt,
    input  wire logic        debug_enable,
    input  wire logic        in_debug_mode,
    input  wire logic        msr_ri,
    output logic      [31:0] spr_rdata,
    output logic             spr_rd_ack,
    output logic             debug_entry_req,
    output logic      [1:0]  lbus_watch
);
    typedef struct packed {
        logic [31:0] lctl;
        logic [31:0] cause;
        logic [31:0] mask;
        logic [31:0] rdata;
        logic        rd_ack;
        logic        entry;
        logic [1:0]  lwatch;
    } bdc_top_state_type;

    bdc_top_state_type r_ff;
    bdc_top_state_type nxt_r;

    logic [1:0]  lw_hit;
    logic [1:0]  trap_en;
    logic [31:0] cnt_a_val;
    logic [31:0] cnt_b_val;
    logic        a_exp_i;
    logic        a_exp_l;
    logic        b_exp_i;
    logic        b_exp_l;
    logic        wr_cnt_a;
    logic        wr_cnt_b;
    logic        brk_ok;
    logic        loadbus_breakpoint_cause;
    logic        instrbus_breakpoint_cause;
    logic        rd_clr_ok;
    logic [31:0] set_evt;

    // ****************************************************************
    // Watchpoints and counters
    // ****************************************************************
    bdc_lwatch u_lw0 (
        .ctl        (r_ff.lctl[bdc_pkg::LW0_LSB +: bdc_pkg::LW_SLICE_W]),
        .ibus_watch (ibus_watch),
        .cmp_match  (cmp_match),
        .hit        (lw_hit[0])
    );

    bdc_lwatch u_lw1 (
        .ctl        (r_ff.lctl[bdc_pkg::LW1_LSB +: bdc_pkg::LW_SLICE_W]),
        .ibus_watch (ibus_watch),
        .cmp_match  (cmp_match),
        .hit        (lw_hit[1])
    );

    assign wr_cnt_a = spr_wr_en && spr_addr == bdc_pkg::SPR_CNT_A;
    assign wr_cnt_b = spr_wr_en && spr_addr == bdc_pkg::SPR_CNT_B;

    bdc_bp_counter u_cnt_a (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .wr_en     (wr_cnt_a),
        .wdata     (spr_wdata),
        .ibus_evt  (ibus_watch[0]),
        .lbus_evt  (lw_hit[0]),
        .reg_value (cnt_a_val),
        .exp_ibus  (a_exp_i),
        .exp_lbus  (a_exp_l)
    );

    bdc_bp_counter u_cnt_b (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .wr_en     (wr_cnt_b),
        .wdata     (spr_wdata),
        .ibus_evt  (ibus_watch[1]),
        .lbus_evt  (lw_hit[1]),
        .reg_value (cnt_b_val),
        .exp_ibus  (b_exp_i),
        .exp_lbus  (b_exp_l)
    );

    // ****************************************************************
    // Breakpoint causes
    // ****************************************************************
    // Masked mode hides breakpoints while the state is not recoverable
    assign brk_ok  = msr_ri | r_ff.lctl[bdc_pkg::BRK_NOMASK];
    assign trap_en = {r_ff.lctl[bdc_pkg::SLW1_BIT],
                      r_ff.lctl[bdc_pkg::SLW0_BIT]};
    assign loadbus_breakpoint_cause    = brk_ok & (a_exp_l | b_exp_l | (|(lw_hit & trap_en)));
    assign instrbus_breakpoint_cause    = brk_ok & (a_exp_i | b_exp_i
                             | core_cause_evt[bdc_pkg::CAUSE_INSTRBUS_BREAKPOINT_CAUSE]);

    always_comb begin
        set_evt = core_cause_evt & bdc_pkg::CAUSE_VALID;
        set_evt[bdc_pkg::CAUSE_LOADBUS_BREAKPOINT_CAUSE] = loadbus_breakpoint_cause;
        set_evt[bdc_pkg::CAUSE_INSTRBUS_BREAKPOINT_CAUSE] = instrbus_breakpoint_cause;
    end

    assign rd_clr_ok = !debug_enable || in_debug_mode;

    // ****************************************************************
    // Register access and cause tracking
    // ****************************************************************
    always_comb begin
        nxt_r        = r_ff;
        nxt_r.rd_ack = 1'b0;
        nxt_r.entry  = 1'b0;
        nxt_r.lwatch = lw_hit;
        if (spr_rd_en) begin
            nxt_r.rd_ack = 1'b1;
            case (spr_addr)
                bdc_pkg::SPR_CAUSE: begin
                    nxt_r.rdata = r_ff.cause;
                    if (rd_clr_ok) begin
                        nxt_r.cause = bdc_pkg::CAUSE_RESET;
                    end
                end
                bdc_pkg::SPR_MASK:  nxt_r.rdata = r_ff.mask;
                bdc_pkg::SPR_CNT_A: nxt_r.rdata = cnt_a_val;
                bdc_pkg::SPR_CNT_B: nxt_r.rdata = cnt_b_val;
                bdc_pkg::SPR_LCTL:  nxt_r.rdata = r_ff.lctl;
                default:            nxt_r.rdata = bdc_pkg::RDATA_ZERO;
            endcase
        end
        if (spr_wr_en) begin
            // Cause register is absent here: writes to it fall away
            case (spr_addr)
                bdc_pkg::SPR_LCTL:
                    nxt_r.lctl = spr_wdata & bdc_pkg::LCTL_WMASK;
                bdc_pkg::SPR_MASK:
                    nxt_r.mask = spr_wdata & bdc_pkg::CAUSE_VALID;
                default: ;
            endcase
        end
        // New events win over a clearing read in the same cycle
        nxt_r.cause = nxt_r.cause | set_evt;
        nxt_r.entry = debug_enable && |(set_evt & r_ff.mask);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_ff.lctl   <= bdc_pkg::LCTL_RESET;
            r_ff.cause  <= bdc_pkg::CAUSE_RESET;
            r_ff.mask   <= bdc_pkg::MASK_RESET;
            r_ff.rdata  <= bdc_pkg::RDATA_ZERO;
            r_ff.rd_ack <= 1'b0;
            r_ff.entry  <= 1'b0;
            r_ff.lwatch <= 2'h0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign spr_rdata       = r_ff.rdata;
    assign spr_rd_ack      = r_ff.rd_ack;
    assign debug_entry_req = r_ff.entry;
    assign lbus_watch      = r_ff.lwatch;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_lctl_reset: assert property (disable iff (1'b0)
        !rst_n |-> r_ff.lctl == bdc_pkg::LCTL_RESET)
        else $error("watch control not clear in reset");
    a_lw_three_cond: assert property (
        lbus_watch[0] |-> $past(r_ff.lctl[bdc_pkg::LW0_LSB
            + bdc_pkg::LWS_EN]) && ($past(ibus_watch) != 4'h0
            || !$past(r_ff.lctl[bdc_pkg::LW0_LSB + bdc_pkg::LWS_IADC])))
        else $error("watchpoint fired without its conditions");
    a_lw_disabled: assert property (
        !r_ff.lctl[bdc_pkg::LW1_LSB + bdc_pkg::LWS_EN] |=> !lbus_watch[1])
        else $error("disabled watchpoint fired");
    a_cause_reset: assert property (disable iff (1'b0)
        !rst_n |-> r_ff.cause == bdc_pkg::CAUSE_RESET)
        else $error("cause not clear in reset");
    a_cause_rd_clr: assert property (
        spr_rd_en && spr_addr == bdc_pkg::SPR_CAUSE && rd_clr_ok
        && set_evt == 32'h0 |=> r_ff.cause == 32'h0
        && spr_rdata == $past(r_ff.cause))
        else $error("cause read did not clear");
    a_cause_rd_keep: assert property (
        spr_rd_en && spr_addr == bdc_pkg::SPR_CAUSE && !rd_clr_ok
        |=> r_ff.cause == ($past(r_ff.cause) | $past(set_evt)))
        else $error("cause cleared outside debug");
    a_cause_no_wr: assert property (
        spr_wr_en && !spr_rd_en && set_evt == 32'h0 |=> $stable(r_ff.cause))
        else $error("write changed cause");
    a_cause_sticky: assert property (
        core_cause_evt[bdc_pkg::CAUSE_CHECKSTOP_CAUSE]
        |=> r_ff.cause[bdc_pkg::CAUSE_CHECKSTOP_CAUSE])
        else $error("checkstop not recorded");
    a_entry_gate: assert property (
        debug_entry_req |-> $past(debug_enable)
        && $past(set_evt & r_ff.mask) != 32'h0)
        else $error("debug entry without enabled cause");
    a_entry_taken: assert property (
        debug_enable && (set_evt & r_ff.mask) != 32'h0 |=> debug_entry_req)
        else $error("enabled cause did not request entry");
    a_mask_rsvd: assert property (
        (r_ff.mask & ~bdc_pkg::CAUSE_VALID) == 32'h0)
        else $error("reserved mask bit set");

    c_rd_clear: cover property (
        spr_rd_en && spr_addr == bdc_pkg::SPR_CAUSE && r_ff.cause != 32'h0);
    c_entry: cover property (debug_entry_req);
    c_lw_hit: cover property (lbus_watch != 2'h0);

endmodule // bdc_debug_core
`default_nettype wire

// ---- rtl/bdc_lwatch.sv ----
`timescale 1ns/1ps
`default_nettype none
module bdc_lwatch (
    input  wire logic [9:0] ctl,
    input  wire logic [3:0] ibus_watch,
    input  wire logic [3:0] cmp_match,
    output logic            hit
);
    logic ia_ok;
    logic la_ok;
    logic ld_ok;

    // ****************************************************************
    // Three-way match
    // ****************************************************************
    // Comparators E,F,G,H sit at cmp_match[0..3]
    assign ia_ok = !ctl[bdc_pkg::LWS_IADC]
                 | ibus_watch[ctl[bdc_pkg::LWS_IA +: 2]];
    assign la_ok = !ctl[bdc_pkg::LWS_LADC]
                 | bdc_pkg::bdc_pair_sel(ctl[bdc_pkg::LWS_LA +: 2],
                                         cmp_match[0], cmp_match[1]);
    assign ld_ok = !ctl[bdc_pkg::LWS_LDDC]
                 | bdc_pkg::bdc_pair_sel(ctl[bdc_pkg::LWS_LD +: 2],
                                         cmp_match[2], cmp_match[3]);
    assign hit = ctl[bdc_pkg::LWS_EN] & ia_ok & la_ok & ld_ok;

endmodule // bdc_lwatch
`default_nettype wire

// ---- test/bdc_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Core-side event source: watchpoints, comparators, exceptions
// ****************************************************************
module bdc_core_model (
    input  wire logic        sys_clk,
    output logic      [3:0]  ibus_watch,
    output logic      [3:0]  cmp_match,
    output logic      [31:0] core_cause_evt,
    output logic             debug_enable,
    output logic             in_debug_mode,
    output logic             msr_ri
);
    initial begin
        ibus_watch     = 4'h0;
        cmp_match      = 4'h0;
        core_cause_evt = 32'h0000_0000;
        debug_enable   = 1'b0;
        in_debug_mode  = 1'b0;
        msr_ri         = 1'b1;
    end

    task automatic set_ri(input logic ri);
        msr_ri = ri;
    endtask

    task automatic set_mode(input logic en, input logic dm);
        debug_enable  = en;
        in_debug_mode = dm;
    endtask

    // Events are single-cycle; the caller lets a cycle pass before the next
    task automatic fire(input logic [3:0] iw, input logic [3:0] cm,
                        input logic [31:0] ev);
        ibus_watch     = iw;
        cmp_match      = cm;
        core_cause_evt = ev;
        @(posedge sys_clk);
        #1;
        ibus_watch     = 4'h0;
        cmp_match      = 4'h0;
        core_cause_evt = 32'h0000_0000;
    endtask
endmodule // bdc_core_model
`default_nettype wire

// ---- test/breakpoint_counter_cause_logic_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module breakpoint_counter_cause_logic_test;
    logic        sys_clk;
    logic        rst_n;
    logic        spr_wr_en;
    logic        spr_rd_en;
    logic [9:0]  spr_addr;
    logic [31:0] spr_wdata;
    logic [3:0]  ibus_watch;
    logic [3:0]  cmp_match;
    logic [31:0] core_cause_evt;
    logic        debug_enable;
    logic        in_debug_mode;
    logic        msr_ri;
    logic [31:0] spr_rdata;
    logic        spr_rd_ack;
    logic        debug_entry_req;
    logic [1:0]  lbus_watch;
    int          miscompares;
    int          num_checks;
    logic [31:0] exp_cause;
    logic [31:0] rd;
    logic [31:0] ev;
    logic [31:0] msk;
    logic [3:0]  iw;
    logic [9:0]  ca;
    logic        hit;

    bdc_debug_core DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .spr_wr_en(spr_wr_en),
        .spr_rd_en(spr_rd_en), .spr_addr(spr_addr), .spr_wdata(spr_wdata),
        .ibus_watch(ibus_watch), .cmp_match(cmp_match),
        .core_cause_evt(core_cause_evt), .debug_enable(debug_enable),
        .in_debug_mode(in_debug_mode), .msr_ri(msr_ri),
        .spr_rdata(spr_rdata), .spr_rd_ack(spr_rd_ack),
        .debug_entry_req(debug_entry_req), .lbus_watch(lbus_watch));

    bdc_core_model core (
        .sys_clk(sys_clk), .ibus_watch(ibus_watch), .cmp_match(cmp_match),
        .core_cause_evt(core_cause_evt), .debug_enable(debug_enable),
        .in_debug_mode(in_debug_mode), .msr_ri(msr_ri));

    // ****************************************************************
    // Bus and compare helpers
    // ****************************************************************
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    // Trailing idle cycle keeps strobes from toggling twice in one step
    task automatic spr_write(input logic [9:0] a, input logic [31:0] d);
        spr_wr_en = 1'b1;
        spr_addr  = a;
        spr_wdata = d;
        tick();
        spr_wr_en = 1'b0;
        tick();
    endtask

    task automatic spr_read(input logic [9:0] a, output logic [31:0] d);
        spr_rd_en = 1'b1;
        spr_addr  = a;
        tick();
        spr_rd_en = 1'b0;
        check({31'h0, spr_rd_ack}, 32'h1, "read ack");
        d = spr_rdata;
        tick();
    endtask

    // Model: sticky cause, cleared by read only outside normal debug
    task automatic read_cause;
        spr_read(bdc_pkg::SPR_CAUSE, rd);
        check(rd, exp_cause, "cause");
        if (!debug_enable || in_debug_mode) begin
            exp_cause = 32'h0;
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Whole run is well under a thousand cycles; this is a generous ceiling
    initial begin
        #(5 * 20000);
        miscompares++;
        wrap_up();
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        rst_n       = 1'b0;
        spr_wr_en   = 1'b0;
        spr_rd_en   = 1'b0;
        spr_addr    = 10'h000;
        spr_wdata   = 32'h0000_0000;
        miscompares = 0;
        num_checks  = 0;
        exp_cause   = 32'h0;
        void'($urandom(32'hcfc8));
        repeat (10) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        tick();

        spr_read(bdc_pkg::SPR_LCTL, rd);
        check(rd, 32'h0000_0000, "watch ctl reset");
        spr_read(bdc_pkg::SPR_CNT_A, rd);
        check(rd & 32'h0000_ffff, 32'h0, "count a reset");
        spr_read(bdc_pkg::SPR_CNT_B, rd);
        check(rd & 32'h0000_ffff, 32'h0, "count b reset");
        spr_read(bdc_pkg::SPR_MASK, rd);
        check(rd, 32'h2002_000f, "mask reset");
        read_cause();
        spr_read(10'h3ff, rd);
        check(rd, 32'h0, "unmapped read");
        spr_write(bdc_pkg::SPR_CAUSE, 32'hffff_ffff);
        read_cause();
        $display("test reset and write-ignore done");

        // Breakpoint bit 3 is internal only, so it is left out here
        for (int i = 0; i < 40; i++) begin
            msk = $urandom();
            spr_write(bdc_pkg::SPR_MASK, msk);
            spr_read(bdc_pkg::SPR_MASK, rd);
            check(rd, msk & 32'h3fe7_400f, "mask");
            core.set_mode(1'($urandom_range(1)), 1'($urandom_range(1)));
            ev = $urandom() & 32'h3fe7_4007 & {32{1'($urandom_range(1))}};
            core.fire(4'h0, 4'h0, ev);
            hit = debug_enable && ((ev & msk & 32'h3fe7_400f) != 32'h0);
            check({31'h0, debug_entry_req}, {31'h0, hit}, "entry");
            exp_cause = exp_cause | ev;
            read_cause();
            read_cause();
        end
        $display("test cause and entry done");

        spr_write(bdc_pkg::SPR_LCTL, 32'hd274_9000);
        spr_read(bdc_pkg::SPR_LCTL, rd);
        check(rd, 32'hd274_9000, "watch ctl");
        for (int i = 0; i < 32; i++) begin
            iw = (4'($urandom_range(15)) & 4'hb) | {1'b0, i[4], 2'b00};
            core.fire(iw, i[3:0], 32'h0);
            hit = iw[2] & i[0] & i[2];
            check({30'h0, lbus_watch}, {30'h0, hit, hit}, "lbus");
            tick();
        end
        $display("test watchpoint conditions done");

        core.set_mode(1'b0, 1'b0);
        for (int k = 0; k < 2; k++) begin
            for (int s = 0; s < 4; s++) begin
                ca = (k == 0) ? bdc_pkg::SPR_CNT_A : bdc_pkg::SPR_CNT_B;
                spr_write(ca, {16'h0002, 14'h3fff, s[1:0]});
                spr_read(ca, rd);
                check(rd, {16'h0002, 14'h0, s[1:0]}, "count src");
                for (int j = 0; j < 4; j++) begin
                    core.fire((j < 2) ? 4'(1 << k) : 4'h4,
                              (j < 2) ? 4'h0 : 4'h5, 32'h0);
                    tick();
                end
                repeat (6) tick();
                hit = (s == 1) || (s == 2);
                spr_read(ca, rd);
                check(rd, {hit ? 16'h0 : 16'h2, 14'h0, s[1:0]},
                      "count value");
                if (s == 1) begin
                    exp_cause = exp_cause | 32'h4;
                end
                if (s == 2) begin
                    exp_cause = exp_cause | 32'h8;
                end
                read_cause();
            end
        end
        $display("test breakpoint counters done");

        // Trap-enabled watch 0 breaks only in recoverable state or nomask
        spr_write(bdc_pkg::SPR_LCTL, 32'hd274_9008);
        core.set_ri(1'b0);
        core.fire(4'h4, 4'h5, 32'h0);
        tick();
        read_cause();
        core.set_ri(1'b1);
        core.fire(4'h4, 4'h5, 32'h0);
        tick();
        exp_cause = exp_cause | 32'h8;
        read_cause();
        spr_write(bdc_pkg::SPR_LCTL, 32'hd274_9808);
        core.set_ri(1'b0);
        core.fire(4'h4, 4'h5, 32'h0);
        tick();
        exp_cause = exp_cause | 32'h8;
        read_cause();
        core.set_ri(1'b1);
        $display("test breakpoint masking done");
        wrap_up();
    end
endmodule // breakpoint_counter_cause_logic_test
`default_nettype wire
